// >>> logic/resync_timer.sv
// phase resync timer: counts sync ticks, flags the second one after a load
// assumes a pfd-rate tick input from the analog side
`timescale 1ns/1ps
module resync_timer (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic enable_in,
  input wire logic pfd_tick_in,
  input wire logic [11:0] div_value_in,
  input wire logic [11:0] modulus_in,
  input wire logic restart_in,
  output logic sync_out,
  output logic realign_out
);
  typedef struct packed {
    logic [11:0] div_cnt;
    logic [11:0] tick_cnt;
    logic [1:0] syncs;
    logic sync;
    logic realign;
  } rt_t;
  rt_t s_q, s_d;
  //////////////////////////////////////////////////////////////////
  // interval = div value * modulus pfd ticks
  always_comb
  begin
    s_d = s_q;
    s_d.sync = 1'b0;
    s_d.realign = 1'b0;
    if (!enable_in || restart_in)
    begin
      s_d.div_cnt = '0;
      s_d.tick_cnt = '0;
      if (restart_in)
      begin
        s_d.syncs = '0;
      end
    end
    else if (pfd_tick_in)
    begin
      if (s_q.tick_cnt + 12'h001 >= modulus_in)
      begin
        s_d.tick_cnt = '0;
        if (s_q.div_cnt + 12'h001 >= div_value_in)
        begin
          s_d.div_cnt = '0;
          s_d.sync = 1'b1;
          if (s_q.syncs != synth_ctrl_pkg::SYNC_COUNT_TARGET)
          begin
            s_d.syncs = s_q.syncs + 2'h1;
            // second sync after load realigns
            s_d.realign = (s_q.syncs + 2'h1) == synth_ctrl_pkg::SYNC_COUNT_TARGET;
          end
        end
        else
        begin
          s_d.div_cnt = s_q.div_cnt + 12'h001;
        end
      end
      else
      begin
        s_d.tick_cnt = s_q.tick_cnt + 12'h001;
      end
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign sync_out = s_q.sync;
  assign realign_out = s_q.realign;
endmodule

// >>> logic/shift_loader.sv
// serial word shifter with load-enable edge detect
// assumes data, clock-of-data strobe and load enable are synchronous to CLK_IN
`timescale 1ns/1ps
module shift_loader (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic data_in,
  input wire logic shift_in,
  input wire logic load_enable_in,
  output logic [31:0] word_out,
  output logic load_out
);
  typedef struct packed {
    logic [31:0] sr;
    logic load_prev; // load enable seen at the last edge
  } shl_t;
  shl_t s_q, s_d;
  //////////////////////////////////////////////////////////////////
  // shift on strobe, pulse on load-enable rise
  always_comb
  begin
    s_d = s_q;
    s_d.load_prev = load_enable_in;
    if (shift_in)
    begin
      s_d.sr = {s_q.sr[30:0], data_in}; // msb first
    end
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign word_out = s_q.sr;
  assign load_out = load_enable_in & ~s_q.load_prev; // rising edge
endmodule

// >>> logic/synth_control_word_decoder.sv
// control word decoder for a fractional-n synthesizer
// assumes serial data, shift strobe and load enable synchronous to CLK_IN
// Behaviour
// [R1] control code 2/3/4/5 picks target register
// [R2] shutdown bit one powers down, zero runs
// [R3] registers kept and loadable during shutdown
// [R4] shutdown holds counters, isolates pump, mutes
// [R5] isolate bit three-states the charge pump
// [R6] hold bit resets reference and feedback counters
// [R7] boost adds pump current until near lock
// [R8] host sets reference halver before boost
// [R9] mode 10 resyncs, 00 disables divider
// [R10] twelve-bit divider value sets resync timeout
// [R11] feedback bit picks oscillator or divider output
// [R12] three-bit field selects output divider ratio
// [R13] mute-until-locked holds output off till lock
// [R14] enable bit switches primary output on
// [R15] two-bit field sets output power level
// [R16] host writes antibacklash width as 00
// [R17] charge cancel on; host clears in fractional
// [R18] two-bit field selects lock pin behaviour
// [R19] host programs registers five down to zero
// [R20] host keeps reference and numerator in range
// [R21] second sync after load realigns output phase
// [R22] double buffer bit defers output divider update
// [R23] word lands only on load-enable rise
`timescale 1ns/1ps
module synth_control_word_decoder (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic SER_DATA_IN,
  input wire logic SER_SHIFT_IN,
  input wire logic LOAD_ENABLE_IN,
  input wire logic LOCK_DETECT_IN,
  input wire logic NEAR_LOCK_IN,
  input wire logic PFD_TICK_IN,
  input wire logic [11:0] FRACTION_MODULUS_IN,
  output logic SHUTDOWN_OUT,
  output logic CP_THREE_STATE_OUT,
  output logic COUNTER_RESET_OUT,
  output logic LOCK_DETECT_RESET_OUT,
  output logic BOOST_CELL_OUT,
  output logic REFERENCE_HALVER_OUT,
  output logic [1:0] CLKDIV_MODE_OUT,
  output logic [11:0] CLKDIV_VALUE_OUT,
  output logic SYNC_PULSE_OUT,
  output logic PHASE_REALIGN_OUT,
  output logic FEEDBACK_DIRECT_OUT,
  output logic [2:0] OUTPUT_DIVIDER_OUT,
  output logic RF_OUTPUT_ON_OUT,
  output logic [1:0] RF_POWER_OUT,
  output logic [1:0] ANTIBACKLASH_WIDTH_OUT,
  output logic CHARGE_CANCEL_ENABLE_OUT,
  output logic [1:0] LOCK_INDICATOR_PIN_MODE_OUT,
  output logic [31:0] REG2_WORD_OUT
);
  //////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [31:0] reg2; // shutdown / pump / counter bits
    logic [31:0] reg3; // boost_resync_config_word
    logic [31:0] reg4; // output_path_config_word
    logic [31:0] reg5; // lock_pin_pfd_config_word
    logic [2:0] odiv_pend; // output divider waiting for reg0 write
    logic [2:0] odiv_act; // output divider in use
    logic boost_done; // boost already released since the last reg0 write
    logic [31:0] out_flags; // registered outputs, packed below
  } st_t;
  st_t s_q, s_d;
  logic [31:0] word; // shifted word
  logic load; // load-enable rising pulse
  logic sync_p; // resync interval tick
  logic realign_p; // second sync after load
  logic resync_en; // resync mode active
  //////////////////////////////////////////////////////////////////
  // field extraction helper
  function automatic logic [1:0] field2(input logic [31:0] w, input int lo);
    field2 = w[lo +: 2];
  endfunction
  //////////////////////////////////////////////////////////////////
  // serial front end
  shift_loader u_shift (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .data_in(SER_DATA_IN),
    .shift_in(SER_SHIFT_IN),
    .load_enable_in(LOAD_ENABLE_IN),
    .word_out(word),
    .load_out(load)
  );
  assign resync_en = field2(s_q.reg3, synth_ctrl_pkg::BRC_MODE_LO)
    == synth_ctrl_pkg::CLKDIV_RESYNC; // [R9]
  resync_timer u_resync (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .enable_in(resync_en),
    .pfd_tick_in(PFD_TICK_IN),
    .div_value_in(s_q.reg3[synth_ctrl_pkg::BRC_DIV_HI:synth_ctrl_pkg::BRC_DIV_LO]), // [R10]
    .modulus_in(FRACTION_MODULUS_IN),
    .restart_in(load), // [R21]
    .sync_out(sync_p),
    .realign_out(realign_p)
  );
  //////////////////////////////////////////////////////////////////
  // register load and derived controls
  always_comb
  begin
    logic sd;
    logic [1:0] mode;
    sd = 1'b0;
    mode = 2'h0;
    s_d = s_q;
    // loading continues regardless of shutdown
    if (load) // [R23] [R3]
    begin
      case (word[2:0]) // [R1]
        synth_ctrl_pkg::CTL_REG2: s_d.reg2 = word;
        synth_ctrl_pkg::CTL_REG3: s_d.reg3 = word;
        synth_ctrl_pkg::CTL_REG4: s_d.reg4 = word;
        synth_ctrl_pkg::CTL_REG5: s_d.reg5 = word;
        default: s_d.reg2 = s_q.reg2; // other words not held here
      endcase
      if (word[2:0] == synth_ctrl_pkg::CTL_REG4)
      begin
        s_d.odiv_pend = word[synth_ctrl_pkg::OPC_ODIV_HI:synth_ctrl_pkg::OPC_ODIV_LO];
        if (!s_q.reg2[synth_ctrl_pkg::R2_DBL_BUF])
        begin
          s_d.odiv_act = s_d.odiv_pend; // [R22] direct when unbuffered
        end
      end
      if (word[2:0] == synth_ctrl_pkg::CTL_REG0)
      begin
        s_d.odiv_act = s_q.odiv_pend; // [R22] buffered value takes effect
        s_d.boost_done = 1'b0; // new frequency re-arms boost
      end
    end
    if (NEAR_LOCK_IN)
    begin
      s_d.boost_done = 1'b1; // [R7] revert to programmed current
    end
    sd = s_d.reg2[synth_ctrl_pkg::R2_SHUTDOWN]; // [R2]
    mode = field2(s_d.reg3, synth_ctrl_pkg::BRC_MODE_LO);
    s_d.out_flags = '0;
    s_d.out_flags[0] = sd;
    s_d.out_flags[1] = sd | s_d.reg2[synth_ctrl_pkg::R2_CP_ISOLATE]; // [R4] [R5]
    s_d.out_flags[2] = sd | s_d.reg2[synth_ctrl_pkg::R2_CNT_HOLD]; // [R4] [R6]
    s_d.out_flags[3] = sd; // [R4] lock detector reset
    s_d.out_flags[4] = s_d.reg3[synth_ctrl_pkg::BRC_BOOST] & ~s_d.boost_done & ~sd; // [R7]
    s_d.out_flags[5] = ~sd & s_d.reg4[synth_ctrl_pkg::OPC_RF_EN] // [R14] [R4]
      & ~(s_d.reg4[synth_ctrl_pkg::OPC_MUTE] & ~LOCK_DETECT_IN); // [R13]
    s_d.out_flags[6] = s_d.reg4[synth_ctrl_pkg::OPC_FB_SRC]; // [R11]
    s_d.out_flags[7] = s_d.reg5[synth_ctrl_pkg::LPC_CHG_CANCEL]; // [R17]
    s_d.out_flags[9:8] = (mode == synth_ctrl_pkg::CLKDIV_OFF) ? 2'h0 : mode; // [R9]
  end
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  //////////////////////////////////////////////////////////////////
  // outputs from flip-flops
  assign SHUTDOWN_OUT = s_q.out_flags[0];
  assign CP_THREE_STATE_OUT = s_q.out_flags[1];
  assign COUNTER_RESET_OUT = s_q.out_flags[2];
  assign LOCK_DETECT_RESET_OUT = s_q.out_flags[3];
  assign BOOST_CELL_OUT = s_q.out_flags[4];
  assign RF_OUTPUT_ON_OUT = s_q.out_flags[5];
  assign FEEDBACK_DIRECT_OUT = s_q.out_flags[6];
  assign CHARGE_CANCEL_ENABLE_OUT = s_q.out_flags[7];
  assign CLKDIV_MODE_OUT = s_q.out_flags[9:8];
  assign REFERENCE_HALVER_OUT = s_q.reg2[synth_ctrl_pkg::R2_REF_HALVER]; // [R8]
  assign CLKDIV_VALUE_OUT = s_q.reg3[synth_ctrl_pkg::BRC_DIV_HI:synth_ctrl_pkg::BRC_DIV_LO];
  assign OUTPUT_DIVIDER_OUT = s_q.odiv_act; // [R12]
  assign RF_POWER_OUT = field2(s_q.reg4, synth_ctrl_pkg::OPC_PWR_LO); // [R15]
  assign ANTIBACKLASH_WIDTH_OUT = field2(s_q.reg5, synth_ctrl_pkg::LPC_BACKLASH_LO); // [R16]
  assign LOCK_INDICATOR_PIN_MODE_OUT = field2(s_q.reg5, synth_ctrl_pkg::LPC_LOCKPIN_LO); // [R18]
  assign SYNC_PULSE_OUT = sync_p;
  assign PHASE_REALIGN_OUT = realign_p; // [R21]
  assign REG2_WORD_OUT = s_q.reg2;
endmodule

// >>> logic/synth_ctrl_pkg.sv
// constants for the synthesizer control word decoder
// assumes a 32-bit word shifted msb first, control field in bits 2:0
package synth_ctrl_pkg;
  localparam int WORD_W = 32;
  localparam logic [2:0] CTL_REG0 = 3'h0;
  localparam logic [2:0] CTL_REG1 = 3'h1;
  localparam logic [2:0] CTL_REG2 = 3'h2;
  localparam logic [2:0] CTL_REG3 = 3'h3;
  localparam logic [2:0] CTL_REG4 = 3'h4;
  localparam logic [2:0] CTL_REG5 = 3'h5;
  // register 2 fields
  localparam int R2_REF_HALVER = 24;
  localparam int R2_DBL_BUF = 13;
  localparam int R2_SHUTDOWN = 5;
  localparam int R2_CP_ISOLATE = 4;
  localparam int R2_CNT_HOLD = 3;
  // register 3 fields
  localparam int BRC_BOOST = 18;
  localparam int BRC_MODE_HI = 16;
  localparam int BRC_MODE_LO = 15;
  localparam int BRC_DIV_HI = 14;
  localparam int BRC_DIV_LO = 3;
  localparam logic [1:0] CLKDIV_OFF = 2'h0;
  localparam logic [1:0] CLKDIV_RESYNC = 2'h2;
  // register 4 fields
  localparam int OPC_FB_SRC = 23;
  localparam int OPC_ODIV_HI = 22;
  localparam int OPC_ODIV_LO = 20;
  localparam int OPC_MUTE = 10;
  localparam int OPC_RF_EN = 5;
  localparam int OPC_PWR_HI = 4;
  localparam int OPC_PWR_LO = 3;
  // register 5 fields
  localparam int LPC_BACKLASH_HI = 31;
  localparam int LPC_BACKLASH_LO = 30;
  localparam int LPC_CHG_CANCEL = 29;
  localparam int LPC_LOCKPIN_HI = 23;
  localparam int LPC_LOCKPIN_LO = 22;
  localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;
  localparam logic [1:0] SYNC_COUNT_TARGET = 2'h2;
endpackage

// >>> tb/synth_control_word_decoder_bench.sv
// self-checking bench for the control word decoder
// assumes the host model drives the serial pins
`timescale 1ns/1ps
module synth_control_word_decoder_bench;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic lock_in = 1'b0;
  logic near_in = 1'b0;
  logic tick_in = 1'b0;
  logic ser_data, ser_shift, ser_load;
  logic shut, cp, cnt, ldr, boost, halver, sync, realign, fb, rf_on, ccan;
  logic [1:0] mode, pwr, abw, ldm;
  logic [2:0] odiv;
  logic [11:0] divv;
  logic [31:0] r2w;
  int miscompares = 0;
  int comparisons = 0;
  int syncs = 0;
  int aligns = 0;
  int align_sync = 0;
  int cycles = 0;
  int k;
  synth_host_model host (.clk_in(clk_in), .data_out(ser_data), .shift_out(ser_shift),
    .load_enable_out(ser_load));
  synth_control_word_decoder uut (.CLK_IN(clk_in), .RST_B_IN(rst_b_in),
    .SER_DATA_IN(ser_data), .SER_SHIFT_IN(ser_shift), .LOAD_ENABLE_IN(ser_load),
    .LOCK_DETECT_IN(lock_in), .NEAR_LOCK_IN(near_in), .PFD_TICK_IN(tick_in),
    .FRACTION_MODULUS_IN(12'h002), .SHUTDOWN_OUT(shut), .CP_THREE_STATE_OUT(cp),
    .COUNTER_RESET_OUT(cnt), .LOCK_DETECT_RESET_OUT(ldr), .BOOST_CELL_OUT(boost),
    .REFERENCE_HALVER_OUT(halver), .CLKDIV_MODE_OUT(mode), .CLKDIV_VALUE_OUT(divv),
    .SYNC_PULSE_OUT(sync), .PHASE_REALIGN_OUT(realign), .FEEDBACK_DIRECT_OUT(fb),
    .OUTPUT_DIVIDER_OUT(odiv), .RF_OUTPUT_ON_OUT(rf_on), .RF_POWER_OUT(pwr),
    .ANTIBACKLASH_WIDTH_OUT(abw), .CHARGE_CANCEL_ENABLE_OUT(ccan),
    .LOCK_INDICATOR_PIN_MODE_OUT(ldm), .REG2_WORD_OUT(r2w));
  // 200 mhz clock
  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end
  // pfd tick every other cycle, pulse counters, hang guard
  always @(posedge clk_in)
  begin
    tick_in <= ~tick_in;
    cycles++;
    syncs += int'(sync);
    aligns += int'(realign);
    // which sync since the last clear carried the realign
    if (realign)
    begin
      align_sync = syncs;
    end
    if (cycles == 5000)
    begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one word in, then outputs settle
  task automatic wr(input logic [31:0] w);
    host.send(w);
    repeat (3) @(posedge clk_in);
  endtask
  task automatic end_sim();
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    chk(32'({shut, cp, cnt, ldr, rf_on}), 32'h0);
    for (k = 5; k >= 0; k--)
      wr(32'(k));
    wr(32'h0100_0022);
    chk(32'({halver, shut, cp, cnt, ldr}), 32'h1f);
    wr(32'h00b0_0034);
    chk(32'({fb, odiv, rf_on, pwr}), 32'h5a);
    wr(32'h0000_001a);
    chk(32'({halver, shut, cp, cnt, ldr}), 32'h06);
    chk(32'({fb, odiv, rf_on, pwr}), 32'h5e);
    wr(32'h00b0_0434);
    chk(32'(rf_on), 32'h0);
    lock_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(32'(rf_on), 32'h1);
    wr(32'h20c0_0005);
    wr(32'hffff_fffe);
    chk(32'({abw, ccan, ldm}), 32'h07);
    chk(r2w, 32'h0000_001a);
    @(negedge clk_in);
    aligns = 0;
    syncs = 0;
    wr(32'h0005_0013);
    chk(32'({boost, mode, divv}), 32'h6002);
    repeat (60) @(posedge clk_in);
    chk(32'(aligns), 32'h1);
    chk(32'(align_sync), 32'h2);
    near_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(32'(boost), 32'h0);
    near_in <= 1'b0;
    // re-arm boost while shut down, then wake up
    wr(32'h0000_0022);
    wr(32'h0000_0000);
    chk(32'({boost, shut}), 32'h1);
    wr(32'h0000_0002);
    chk(32'(boost), 32'h1);
    wr(32'h0000_0013);
    @(negedge clk_in);
    syncs = 0;
    repeat (60) @(posedge clk_in);
    chk(32'(syncs), 32'h0);
    wr(32'h0000_2002);
    wr(32'h0050_0024);
    chk(32'(odiv), 32'h3);
    wr(32'h0000_0000);
    chk(32'(odiv), 32'h5);
    end_sim();
  end
endmodule

// >>> tb/synth_control_word_decoder_chk.sv
// port checker for the control word decoder
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/1ps
module synth_control_word_decoder_chk (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire logic LOAD_ENABLE_IN,
  input wire logic NEAR_LOCK_IN,
  input wire logic SHUTDOWN_OUT,
  input wire logic CP_THREE_STATE_OUT,
  input wire logic COUNTER_RESET_OUT,
  input wire logic LOCK_DETECT_RESET_OUT,
  input wire logic BOOST_CELL_OUT,
  input wire logic [1:0] CLKDIV_MODE_OUT,
  input wire logic [11:0] CLKDIV_VALUE_OUT,
  input wire logic SYNC_PULSE_OUT,
  input wire logic PHASE_REALIGN_OUT,
  input wire logic RF_OUTPUT_ON_OUT,
  input wire logic [1:0] RF_POWER_OUT
);
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  // near lock seen on two edges
  sequence near_held;
    NEAR_LOCK_IN [*2];
  endsequence
  a_shut_pump_off: assert property (SHUTDOWN_OUT |-> CP_THREE_STATE_OUT)
    else $error("pump not isolated in shutdown");
  a_shut_counters_held: assert property (SHUTDOWN_OUT |-> COUNTER_RESET_OUT)
    else $error("counters not held in shutdown");
  a_shut_lock_reset: assert property (SHUTDOWN_OUT |-> LOCK_DETECT_RESET_OUT)
    else $error("lock detect not reset in shutdown");
  a_shut_rf_off: assert property (SHUTDOWN_OUT [*2] |-> !RF_OUTPUT_ON_OUT)
    else $error("rf output on in shutdown");
  a_boost_near_end: assert property (near_held |-> !BOOST_CELL_OUT)
    else $error("boost kept past near lock");
  a_boost_shut_off: assert property (SHUTDOWN_OUT |-> !BOOST_CELL_OUT)
    else $error("boost on in shutdown");
  a_div_load_only: assert property ($changed(CLKDIV_VALUE_OUT) |->
    $past(LOAD_ENABLE_IN) || $past(LOAD_ENABLE_IN, 2))
    else $error("divider value moved without load");
  a_power_load_only: assert property ($changed(RF_POWER_OUT) |->
    $past(LOAD_ENABLE_IN) || $past(LOAD_ENABLE_IN, 2))
    else $error("power level moved without load");
  a_sync_needs_mode: assert property (SYNC_PULSE_OUT |->
    CLKDIV_MODE_OUT == synth_ctrl_pkg::CLKDIV_RESYNC)
    else $error("sync pulse outside resync mode");
  a_realign_on_sync: assert property (PHASE_REALIGN_OUT |-> SYNC_PULSE_OUT)
    else $error("realign without sync");
endmodule
bind synth_control_word_decoder synth_control_word_decoder_chk chk (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .LOAD_ENABLE_IN(LOAD_ENABLE_IN),
  .NEAR_LOCK_IN(NEAR_LOCK_IN), .SHUTDOWN_OUT(SHUTDOWN_OUT),
  .CP_THREE_STATE_OUT(CP_THREE_STATE_OUT), .COUNTER_RESET_OUT(COUNTER_RESET_OUT),
  .LOCK_DETECT_RESET_OUT(LOCK_DETECT_RESET_OUT), .BOOST_CELL_OUT(BOOST_CELL_OUT),
  .CLKDIV_MODE_OUT(CLKDIV_MODE_OUT), .CLKDIV_VALUE_OUT(CLKDIV_VALUE_OUT),
  .SYNC_PULSE_OUT(SYNC_PULSE_OUT), .PHASE_REALIGN_OUT(PHASE_REALIGN_OUT),
  .RF_OUTPUT_ON_OUT(RF_OUTPUT_ON_OUT), .RF_POWER_OUT(RF_POWER_OUT)
);

// >>> tb/synth_host_model.sv
// host model: shifts words msb first, then pulses load enable
// assumes the bench calls send between its checks
`timescale 1ns/1ps
module synth_host_model (
  input wire logic clk_in,
  output logic data_out,
  output logic shift_out,
  output logic load_enable_out
);
  // idle lines low before the first word
  initial
  begin
    data_out = 1'b0;
    shift_out = 1'b0;
    load_enable_out = 1'b0;
  end
  // whole word shifted, then one load pulse; bench orders the words
  task automatic send(input logic [31:0] w);
    int i;
    for (i = 31; i >= 0; i--)
    begin
      @(posedge clk_in);
      data_out <= w[i];
      shift_out <= 1'b1;
    end
    @(posedge clk_in);
    shift_out <= 1'b0;
    data_out <= ~w[0];
    load_enable_out <= 1'b1;
    @(posedge clk_in);
    load_enable_out <= 1'b0;
  endtask
endmodule
